// ===== hdl/jump_branch_pkg.sv
// Shared types and constants for the indexed jump and bit-clear branch unit.
package jump_branch_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] BRANCH_LEN = 16'h0003;
  localparam logic [15:0] JUMP_LEN = 16'h0001;

  // Operation requested by decode.
  typedef enum logic [2:0] {
    OP_NONE  = 3'b001,
    OP_IJUMP = 3'b010,
    OP_BCLR  = 3'b100
  } op_e;

  // One decoded instruction handed over by fetch/decode.
  typedef struct packed {
    op_e op;
    logic [7:0] accum;
    logic [15:0] pointer;
    logic [7:0] bit_addr;
    logic [7:0] rel;
  } instr_s;

  // Result towards the program counter and the register file.
  typedef struct packed {
    logic pc_load;
    logic [15:0] pc;
    logic taken;
    logic [7:0] bit_addr;
  } result_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } state_e;

endpackage

// ===== hdl/target_adder.sv
// Sixteen-bit target adder, instantiated once for each of the two control transfers.
`timescale 1ns/1ns
module target_adder
  import jump_branch_pkg::*;
(
  // Operands
  input wire logic [15:0] base,
  input wire logic [15:0] offset,
  // Sum
  output logic [15:0] sum
);

  // The sum wraps modulo 2^16; low-byte carry ripples into the high byte.
  always_comb begin
    sum = base + offset;
  end

endmodule

// ===== hdl/jump_branch_unit.sv
// Execution logic for the indexed indirect jump and the bit-clear branch.
`timescale 1ns/1ns
module jump_branch_unit
  import jump_branch_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoded instruction
  input wire logic instr_valid,
  input wire instr_s instr,
  input wire logic [15:0] pc_cur,
  // Bit read answer
  input wire logic bit_valid,
  input wire logic bit_value,
  // Bit read request
  output logic bit_req,
  output logic [7:0] bit_addr,
  // Program counter update
  output logic pc_load,
  output logic [15:0] pc_next,
  output logic branch_taken,
  output logic busy
);

  typedef struct packed {
    state_e state;
    logic bit_req;
    logic [7:0] bit_addr;
    logic [15:0] target;
    logic [15:0] fall;
    logic pc_load;
    logic [15:0] pc_next;
    logic taken;
  } regs_s;

  regs_s r;
  regs_s next_r;
  logic [15:0] jump_sum;
  logic [15:0] branch_sum;
  logic [15:0] fall_pc;

  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------

  function automatic logic [15:0] sign_ext(input logic [7:0] b);
    sign_ext = {{8{b[7]}}, b};
  endfunction

  assign fall_pc = pc_cur + BRANCH_LEN;

  target_adder u_jump_add (
    .base(instr.pointer),
    .offset({8'h00, instr.accum}),
    .sum(jump_sum)
  );

  target_adder u_branch_add (
    .base(fall_pc),
    .offset(sign_ext(instr.rel)),
    .sum(branch_sum)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------

  // Accumulator, pointer and flags are only read here, never written back,
  // so the jump cannot disturb them.
  always_comb begin
    next_r = r;
    next_r.pc_load = 1'b0;
    next_r.bit_req = 1'b0;
    unique case (r.state)
      ST_IDLE: begin
        if (instr_valid && instr.op == OP_IJUMP) begin
          next_r.pc_load = 1'b1;
          next_r.pc_next = jump_sum;
          next_r.taken = 1'b1;
        end else if (instr_valid && instr.op == OP_BCLR) begin
          next_r.bit_req = 1'b1;
          next_r.bit_addr = instr.bit_addr;
          next_r.target = branch_sum;
          next_r.fall = fall_pc;
          next_r.taken = 1'b0;
          next_r.state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (bit_valid) begin
          next_r.pc_load = 1'b1;
          next_r.taken = ~bit_value;
          next_r.pc_next = bit_value ? r.fall : r.target;
          next_r.state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{state: ST_IDLE, bit_req: 1'b0, bit_addr: 8'h00, target: PC_RESET,
             fall: PC_RESET, pc_load: 1'b0, pc_next: PC_RESET, taken: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign bit_req = r.bit_req;
  assign bit_addr = r.bit_addr;
  assign pc_load = r.pc_load;
  assign pc_next = r.pc_next;
  assign branch_taken = r.taken;
  // The one-hot wait bit is itself a flip-flop, so busy needs no decode.
  assign busy = r.state[1];

endmodule

// ===== tb/jbu_assertions.sv
// Checker for the jump and branch unit.
`timescale 1ns/1ns
module jbu_checker
  import jump_branch_pkg::*;
(
  input wire logic clk, rst, instr_valid, bit_valid, bit_value, bit_req, pc_load, branch_taken, busy,
  input wire instr_s instr,
  input wire logic [15:0] pc_cur, pc_next,
  input wire logic [7:0] bit_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire go = instr_valid && !busy;
  logic [15:0] nxt, tgt, jt;
  always_ff @(posedge clk) if (go) jt <= instr.pointer + {8'h00, instr.accum};
  always_ff @(posedge clk) if (go) nxt <= pc_cur + BRANCH_LEN;
  always_ff @(posedge clk) if (go) tgt <= pc_cur + BRANCH_LEN + {{8{instr.rel[7]}}, instr.rel};
  jump_sum_a: assert property (go && instr.op == OP_IJUMP |=>
    pc_load && branch_taken && pc_next == jt) else $error("jump target wrong");
  jump_only_a: assert property (go && instr.op == OP_IJUMP |=> !bit_req && !busy) else $error("jump side effect");
  bclr_req_a: assert property (go && instr.op == OP_BCLR |=>
    bit_req && busy && bit_addr == $past(instr.bit_addr)) else $error("bit request wrong");
  bclr_test_a: assert property (busy && bit_valid |=>
    pc_load && branch_taken == !$past(bit_value)) else $error("branch decision wrong");
  bclr_wait_a: assert property (busy && !bit_valid |=> busy && !pc_load) else $error("bit wait broken");
  bclr_dest_a: assert property (busy && bit_valid |=>
    pc_next == (branch_taken ? tgt : nxt)) else $error("branch target wrong");
  load_cause_a: assert property (pc_load |-> $past(go) || $past(busy)) else $error("stray load");
  pc_hold_a: assert property (!pc_load |-> $stable(pc_next)) else $error("pc moved");
  cover property (go && instr.op == OP_IJUMP);
  cover property (busy && bit_valid && !bit_value);
  cover property (busy && !bit_valid);
endmodule
bind jump_branch_unit jbu_checker chk_i (.*);

// ===== tb/tb_top.sv
// Self-checking bench for the jump and branch unit.
`timescale 1ns/1ns
module tb_top;
  import jump_branch_pkg::*;
  logic clk = 0, rst = 1, instr_valid = 0, bit_valid = 0, bit_value = 0, b;
  logic bit_req, pc_load, branch_taken, busy;
  logic [15:0] pc_cur = '0, pc_next;
  logic [7:0] bit_addr;
  instr_s instr = '0;
  int mismatches = 0, tests_run = 0, seed = 23864, e;
  always #5 clk = ~clk;
  jump_branch_unit dut (.*);
  task finish_test;
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(int x, logic t);
    tests_run++;
    if (pc_load !== 1'b1 || pc_next !== x[15:0] || branch_taken !== t || busy !== 1'b0) begin
      mismatches++;
      $display("unexpected %0t pc_next %h", $time, pc_next);
    end
  endtask
  initial begin
    #20000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    repeat (80) begin
      instr = 43'({$random(seed), $random(seed)});
      instr.op = ($random(seed) & 1) ? OP_IJUMP : OP_BCLR;
      pc_cur = 16'($random(seed));
      b = 1'($random(seed));
      // Forcing the high byte up makes the sixteen-bit wrap common.
      if (b) instr.pointer[15:8] = 8'hFF;
      e = b ? 0 : $signed(instr.rel);
      instr_valid = 1;
      @(posedge clk);
      #1 instr_valid = 0;
      if (instr.op == OP_BCLR) begin
        repeat (2'($random(seed))) begin
          @(posedge clk);
          #1;
        end
        bit_value = b;
        bit_valid = 1;
        @(posedge clk);
        #1 bit_valid = 0;
      end
      chk(instr.op == OP_IJUMP ? instr.pointer + instr.accum : pc_cur + 3 + e, instr.op == OP_IJUMP || !b);
      @(posedge clk);
      #1;
    end
    finish_test;
  end
endmodule
